// ==== sal_regs.svh ====
/*
 * Register offsets, field positions, kind codes and sizes of the switch
 * address lookup engine. Assumes a 4-port switch with the host on port 0.
 */
// How it works
// RQ1: Packets are processed only while lookup_enable is set; otherwise all are dropped. Directed packets are still forwarded on dir_mask.
// RQ2: Each packet yields a forwarding port mask from port, addresses, type and VLAN. The code never uses the packet type (ltype).
// RQ3: MACs abort errored and control packets unless the pass options are set.
// RQ4: Errored or control packets ended normally go to host port 0 only.
// RQ5: Errored packets to the host get no untagging and no rate-limit drop.
// RQ6: No address learning for errored packets or MAC control frames.
// RQ7: Learning uses the source address; forwarding lookup uses the destination address.
// RQ8: Directed packets from the host bypass the engine without learning or processing.
// RQ9: With host_only_bypass, MAC port packets go to host only; host packets normal.
// RQ10: Deny mode: multicast from unknown vendor prefix goes to host unless supervisory.
// RQ11: Deny mode: unicast from unknown vendor prefix goes to host unless block and secure.
// RQ12: Deny mode off: source matching a vendor-prefix entry goes to host unless supervisory.
// RQ13: Multicast supervisory means super bit; unicast supervisory means block and secure.
// RQ14: Supervisory packets escape rate limiting, vendor-prefix and VLAN drops.
// RQ15: Table entries are one of seven kinds, free through VLAN.
// RQ16: Table capacity is readable in a status register.
// RQ17: Software keeps duplicate addresses out of the table; the hit chosen is arbitrary.
// RQ18: Learning happens for any destination kind and unicast or multicast sources.
// RQ19: Group bit 40 of the source address is cleared before lookup.
// RQ20: All-ones multicast is broadcast and may have its own table entry.
// RQ21: Learned addresses enter as unicast type 11 with block and secure clear.
// RQ22: Source equal to destination: learn or update the address, then drop.
// RQ23: Entry kind code 00 marks a free slot.
// RQ24: Dropping to the host is a port mask holding only port 0.
`ifndef SAL_REGS_SVH
`define SAL_REGS_SVH

`define SAL_PORTS      4
`define SAL_ENTRIES    16
`define SAL_IDX_W      4
`define SAL_LAST_IDX   4'hf
`define SAL_ENT_W      70
`define SAL_HOST_MASK  4'h1
`define SAL_ALL_MASK   4'hf

// Register byte offsets
`define SAL_OFF_CTRL   12'h000
`define SAL_OFF_STATUS 12'h004
`define SAL_OFF_TBLCTL 12'h008
`define SAL_OFF_TBLW0  12'h00c
`define SAL_OFF_TBLW1  12'h010
`define SAL_OFF_TBLW2  12'h014

// Control and table control bits
`define SAL_CTRL_EN     0
`define SAL_CTRL_BYPASS 1
`define SAL_CTRL_DENY   2
`define SAL_TBL_WRITE   31

// Entry fields
`define SAL_F_ADDR   47:0
`define SAL_F_OUI    47:24
`define SAL_F_VLAN   59:48
`define SAL_F_KIND   61:60
`define SAL_F_UTYPE  63:62
`define SAL_F_SECURE 64
`define SAL_F_BLOCK  65
`define SAL_F_SUPER  65
`define SAL_F_PORT   68:66
`define SAL_F_MASK   69:66
`define SAL_GROUP_BIT 40

`define SAL_KIND_FREE  2'h0
`define SAL_KIND_ADDR  2'h1
`define SAL_KIND_VLAN  2'h2
`define SAL_KIND_VADDR 2'h3
`define SAL_UTYPE_OUI  2'h2
`define SAL_UTYPE_LRN  2'h3

`endif

// ==== sal_pkg.sv ====
/*
 * Types of the switch address lookup engine: packet descriptor, forwarding
 * result, control bits and the whole engine state. Needs sal_regs.svh.
 */
`include "sal_regs.svh"
package sal_pkg;

   typedef enum logic [2:0] {
      SAL_IDLE   = 3'h1,
      SAL_SCAN   = 3'h2,
      SAL_DECIDE = 3'h4
   } sal_st_t;

   typedef enum logic [2:0] {
      SAL_K_FREE, SAL_K_MCAST, SAL_K_VMCAST, SAL_K_UCAST,
      SAL_K_OUI, SAL_K_VUCAST, SAL_K_VLAN
   } sal_kind_t;

   typedef struct packed {
      logic [1:0]                 src_port;
      logic [47:0]                dst;
      logic [47:0]                src;
      logic [15:0]                ltype;
      logic [11:0]                vlan;
      logic                       err;
      logic                       ctrl;
      logic                       aborted;
      logic                       directed;
      logic [`SAL_PORTS-1:0]      dir_mask;
   } sal_pkt_t;

   typedef struct packed {
      logic                       valid;
      logic [`SAL_PORTS-1:0]      mask;
      logic                       no_untag;
      logic                       no_rate_drop;
   } sal_fwd_t;

   typedef struct packed {
      logic                       enable;
      logic                       bypass;
      logic                       deny;
   } sal_ctl_t;

   typedef struct packed {
      sal_st_t                                    st;
      logic                                       rdy;
      sal_pkt_t                                   pkt;
      logic [`SAL_IDX_W-1:0]                      idx;
      logic                                       dst_hit;
      logic [`SAL_ENT_W-1:0]                      dst_ent;
      logic                                       src_hit;
      logic [`SAL_IDX_W-1:0]                      src_idx;
      logic                                       oui_hit;
      logic                                       free_hit;
      logic [`SAL_IDX_W-1:0]                      free_idx;
      logic                                       learned;
      logic                                       lrn_new;
      logic [`SAL_IDX_W-1:0]                      lrn_idx;
      sal_ctl_t                                   ctl;
      logic [`SAL_IDX_W-1:0]                      ptr;
      logic [2:0][31:0]                           tblw;
      logic [`SAL_ENTRIES-1:0][`SAL_ENT_W-1:0]    tbl;
      sal_fwd_t                                   fwd;
      logic                                       pready;
      logic                                       pslverr;
      logic [31:0]                                prdata;
   } sal_state_t;

endpackage

// ==== sal_engine.sv ====
/*
 * Address lookup engine: scans the table for each non-directed packet, learns
 * source addresses and hands a port mask to the switch fabric. Assumes an
 * APB master, a packet source honouring pkt_ready and a fabric that takes
 * one result per fwd_o.valid pulse.
 */
`timescale 1ns/1ps
`include "sal_regs.svh"
module sal_engine (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Packets from the port MACs
   input  wire logic              pkt_valid,
   input  sal_pkg::sal_pkt_t      pkt_i,
   output logic                   pkt_ready,
   // Result to the switch fabric
   output sal_pkg::sal_fwd_t      fwd_o
);

   sal_pkg::sal_state_t s;
   sal_pkg::sal_state_t n;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic sal_pkg::sal_kind_t entry_kind(input logic [`SAL_ENT_W-1:0] e);
      sal_pkg::sal_kind_t k;
      k = sal_pkg::SAL_K_FREE;
      case (e[`SAL_F_KIND]) // [RQ15]
         `SAL_KIND_FREE: k = sal_pkg::SAL_K_FREE; // [RQ23]
         `SAL_KIND_VLAN: k = sal_pkg::SAL_K_VLAN;
         `SAL_KIND_ADDR: begin
            if (e[`SAL_GROUP_BIT])
               k = sal_pkg::SAL_K_MCAST;
            else if (e[`SAL_F_UTYPE] == `SAL_UTYPE_OUI)
               k = sal_pkg::SAL_K_OUI;
            else
               k = sal_pkg::SAL_K_UCAST;
         end
         default: k = e[`SAL_GROUP_BIT] ? sal_pkg::SAL_K_VMCAST : sal_pkg::SAL_K_VUCAST;
      endcase
      return k;
   endfunction

   function automatic logic [`SAL_PORTS-1:0] port_bit(input logic [2:0] p);
      return `SAL_PORTS'(`SAL_HOST_MASK << p);
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      return (a == `SAL_OFF_CTRL) || (a == `SAL_OFF_STATUS) || (a == `SAL_OFF_TBLCTL) ||
             (a == `SAL_OFF_TBLW0) || (a == `SAL_OFF_TBLW1) || (a == `SAL_OFF_TBLW2);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [`SAL_ENT_W-1:0] e;
      logic [`SAL_ENT_W-1:0] d;
      sal_pkg::sal_kind_t    k;
      sal_pkg::sal_kind_t    dk;
      logic                  vl_ok;
      logic                  sup;
      logic                  errpkt;
      logic                  deny_hit;
      logic                  learn;
      logic [`SAL_PORTS-1:0] mask;
      e        = s.tbl[s.idx];
      d        = s.dst_ent;
      k        = entry_kind(e);
      dk       = entry_kind(d);
      vl_ok    = 1'b0;
      sup      = 1'b0;
      errpkt   = 1'b0;
      deny_hit = 1'b0;
      learn    = 1'b0;
      mask     = '0;
      n        = s;
      n.fwd.valid = 1'b0;
      n.learned   = 1'b0;
      n.lrn_new   = 1'b0;
      n.pready    = 1'b0;
      n.pslverr   = 1'b0;

      // APB: three-cycle access with one wait state, data and error ride with pready
      if (psel && penable && !s.pready) begin
         n.pready  = 1'b1;
         n.pslverr = !addr_ok(paddr);
         case (paddr)
            `SAL_OFF_CTRL:   n.prdata = {29'h0, s.ctl.deny, s.ctl.bypass, s.ctl.enable};
            `SAL_OFF_STATUS: n.prdata = {!s.rdy, 3'h0, s.fwd.mask, 8'h0, // [RQ16]
                                         16'(`SAL_ENTRIES)};
            `SAL_OFF_TBLCTL: n.prdata = {28'h0, s.ptr};
            `SAL_OFF_TBLW0:  n.prdata = s.tblw[0];
            `SAL_OFF_TBLW1:  n.prdata = s.tblw[1];
            `SAL_OFF_TBLW2:  n.prdata = s.tblw[2];
            default:         n.prdata = 32'h0;
         endcase
      end
      // Writes land only on the edge the master samples pready
      if (psel && penable && pwrite && s.pready && addr_ok(paddr)) begin
         case (paddr)
            `SAL_OFF_CTRL: begin
               n.ctl.enable = pwdata[`SAL_CTRL_EN];
               n.ctl.bypass = pwdata[`SAL_CTRL_BYPASS];
               n.ctl.deny   = pwdata[`SAL_CTRL_DENY];
            end
            `SAL_OFF_TBLCTL: begin
               n.ptr = pwdata[`SAL_IDX_W-1:0];
               if (pwdata[`SAL_TBL_WRITE])
                  n.tbl[pwdata[`SAL_IDX_W-1:0]] = {s.tblw[2][5:0], s.tblw[1], s.tblw[0]};
               else
                  n.tblw = {26'h0, s.tbl[pwdata[`SAL_IDX_W-1:0]]};
            end
            `SAL_OFF_TBLW0: n.tblw[0] = pwdata;
            `SAL_OFF_TBLW1: n.tblw[1] = pwdata;
            `SAL_OFF_TBLW2: n.tblw[2] = pwdata;
            default: ;
         endcase
      end

      // Lookup engine
      case (s.st)
         sal_pkg::SAL_IDLE: begin
            if (pkt_valid && s.rdy) begin
               n.pkt = pkt_i;
               n.pkt.src[`SAL_GROUP_BIT] = 1'b0; // [RQ19]
               if (pkt_i.directed) begin
                  // Straight through, no table access at all
                  n.fwd = '{valid: 1'b1, mask: pkt_i.dir_mask, // [RQ8]
                            no_untag: 1'b0, no_rate_drop: 1'b0};
               end else begin
                  n.st       = sal_pkg::SAL_SCAN;
                  n.idx      = '0;
                  n.dst_hit  = 1'b0;
                  n.src_hit  = 1'b0;
                  n.oui_hit  = 1'b0;
                  n.free_hit = 1'b0;
               end
            end
         end
         sal_pkg::SAL_SCAN: begin
            // First hit wins; duplicates give an arbitrary but stable pick [RQ17]
            vl_ok = (e[`SAL_F_VLAN] == s.pkt.vlan);
            if (!s.dst_hit && e[`SAL_F_ADDR] == s.pkt.dst && // [RQ7]
                (k == sal_pkg::SAL_K_MCAST || k == sal_pkg::SAL_K_UCAST ||
                 ((k == sal_pkg::SAL_K_VMCAST || k == sal_pkg::SAL_K_VUCAST) && vl_ok))) begin
               n.dst_hit = 1'b1; // [RQ20]
               n.dst_ent = e;
            end
            if (!s.src_hit && e[`SAL_F_ADDR] == s.pkt.src && // [RQ7]
                (k == sal_pkg::SAL_K_UCAST || (k == sal_pkg::SAL_K_VUCAST && vl_ok))) begin
               n.src_hit = 1'b1;
               n.src_idx = s.idx;
            end
            if (k == sal_pkg::SAL_K_OUI && e[`SAL_F_OUI] == s.pkt.src[47:24])
               n.oui_hit = 1'b1;
            if (!s.free_hit && k == sal_pkg::SAL_K_FREE) begin // [RQ23]
               n.free_hit = 1'b1;
               n.free_idx = s.idx;
            end
            n.idx = s.idx + 1'b1;
            if (s.idx == `SAL_LAST_IDX)
               n.st = sal_pkg::SAL_DECIDE;
         end
         sal_pkg::SAL_DECIDE: begin
            // Multicast: super bit; unicast: block and secure [RQ13]
            sup = s.dst_hit && ((dk == sal_pkg::SAL_K_MCAST || dk == sal_pkg::SAL_K_VMCAST) ?
                  d[`SAL_F_SUPER] : (d[`SAL_F_BLOCK] && d[`SAL_F_SECURE]));
            errpkt   = s.pkt.err || s.pkt.ctrl;
            deny_hit = s.ctl.deny ? !s.oui_hit : s.oui_hit; // [RQ10] [RQ11] [RQ12]
            n.fwd.no_untag     = 1'b0;
            n.fwd.no_rate_drop = 1'b0;
            if (!s.ctl.enable) begin
               mask = '0; // [RQ1]
            end else if (s.pkt.aborted) begin
               mask = '0; // [RQ3]
            end else if (errpkt) begin
               mask = `SAL_HOST_MASK; // [RQ4]
               n.fwd.no_untag     = 1'b1; // [RQ5]
               n.fwd.no_rate_drop = 1'b1;
            end else if (s.ctl.bypass && s.pkt.src_port != 2'h0) begin
               mask = `SAL_HOST_MASK; // [RQ9]
            end else if (s.pkt.src == s.pkt.dst) begin
               mask = '0; // [RQ22]
            end else if (!sup && deny_hit) begin
               mask = `SAL_HOST_MASK; // [RQ24] [RQ14]
            end else begin
               // Unknown destinations flood; never echo to the ingress port [RQ2]
               if (!s.dst_hit)
                  mask = `SAL_ALL_MASK;
               else if (dk == sal_pkg::SAL_K_MCAST || dk == sal_pkg::SAL_K_VMCAST)
                  mask = d[`SAL_F_MASK];
               else
                  mask = port_bit(d[`SAL_F_PORT]);
               mask = mask & ~port_bit({1'b0, s.pkt.src_port});
               n.fwd.no_untag     = sup; // [RQ14]
               n.fwd.no_rate_drop = sup;
            end
            n.fwd.valid = 1'b1;
            n.fwd.mask  = mask;
            // Any destination kind, cleared source; never on errors [RQ18] [RQ6]
            learn = s.ctl.enable && !s.pkt.aborted && !errpkt;
            if (learn && s.src_hit) begin
               n.tbl[s.src_idx][`SAL_F_PORT] = {1'b0, s.pkt.src_port}; // [RQ22]
               n.learned = 1'b1;
               n.lrn_idx = s.src_idx;
            end else if (learn && s.free_hit) begin
               n.tbl[s.free_idx] = '0;
               n.tbl[s.free_idx][`SAL_F_ADDR]   = s.pkt.src; // [RQ7]
               n.tbl[s.free_idx][`SAL_F_KIND]   = `SAL_KIND_ADDR;
               n.tbl[s.free_idx][`SAL_F_UTYPE]  = `SAL_UTYPE_LRN; // [RQ21]
               n.tbl[s.free_idx][`SAL_F_PORT]   = {1'b0, s.pkt.src_port};
               n.learned = 1'b1;
               n.lrn_new = 1'b1;
               n.lrn_idx = s.free_idx;
            end
            n.st = sal_pkg::SAL_IDLE;
         end
         default: n.st = sal_pkg::SAL_IDLE;
      endcase
      n.rdy = (n.st == sal_pkg::SAL_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s     <= '0;
         s.st  <= sal_pkg::SAL_IDLE;
         s.rdy <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign pready    = s.pready;
   assign prdata    = s.prdata;
   assign pslverr   = s.pslverr;
   assign pkt_ready = s.rdy;
   assign fwd_o     = s.fwd;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_disabled_drop;
      @(posedge ref_clk) disable iff (!reset_n)
      s.fwd.valid && !s.pkt.directed && !$past(s.ctl.enable) |-> s.fwd.mask == '0;
   endproperty
   a_disabled_drop: assert property (p_disabled_drop) else $error("drop missing"); // [RQ1]

   property p_err_host;
      @(posedge ref_clk) disable iff (!reset_n)
      s.fwd.valid && !s.pkt.directed && $past(s.ctl.enable) && !s.pkt.aborted &&
      (s.pkt.err || s.pkt.ctrl) |-> s.fwd.mask == `SAL_HOST_MASK;
   endproperty
   a_err_host: assert property (p_err_host) else $error("errored not host"); // [RQ4]

   property p_err_flags;
      @(posedge ref_clk) disable iff (!reset_n)
      s.st == sal_pkg::SAL_DECIDE && s.ctl.enable && !s.pkt.aborted && s.pkt.err
      |=> s.fwd.valid && s.fwd.no_untag && s.fwd.no_rate_drop;
   endproperty
   a_err_flags: assert property (p_err_flags) else $error("err flags"); // [RQ5]

   property p_no_err_learn;
      @(posedge ref_clk) disable iff (!reset_n)
      s.learned |-> !(s.pkt.err || s.pkt.ctrl) && !s.pkt.directed;
   endproperty
   a_no_err_learn: assert property (p_no_err_learn) else $error("bad learn"); // [RQ6]

   property p_directed;
      @(posedge ref_clk) disable iff (!reset_n)
      s.rdy && pkt_valid && pkt_i.directed |=>
      s.fwd.valid && s.fwd.mask == $past(pkt_i.dir_mask) && s.st == sal_pkg::SAL_IDLE;
   endproperty
   a_directed: assert property (p_directed) else $error("directed touched"); // [RQ8]

   property p_bypass;
      @(posedge ref_clk) disable iff (!reset_n)
      s.fwd.valid && !s.pkt.directed && $past(s.ctl.enable) && $past(s.ctl.bypass) &&
      !s.pkt.aborted && s.pkt.src_port != 2'h0 |-> s.fwd.mask == `SAL_HOST_MASK;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not host"); // [RQ9]

   // Unknown destination can never be supervisory, so deny must send it home
   property p_deny_host;
      @(posedge ref_clk) disable iff (!reset_n)
      s.st == sal_pkg::SAL_DECIDE && s.ctl.enable && s.ctl.deny && !s.oui_hit && !s.dst_hit &&
      !s.pkt.aborted && !s.pkt.err && !s.pkt.ctrl && s.pkt.src != s.pkt.dst
      |=> s.fwd.valid && s.fwd.mask == `SAL_HOST_MASK;
   endproperty
   a_deny_host: assert property (p_deny_host) else $error("deny not host"); // [RQ10] [RQ24]

   property p_self_addr;
      @(posedge ref_clk) disable iff (!reset_n)
      s.fwd.valid && !s.pkt.directed && $past(s.ctl.enable) && !$past(s.ctl.bypass) &&
      !s.pkt.aborted && !s.pkt.err && !s.pkt.ctrl && s.pkt.src == s.pkt.dst
      |-> s.fwd.mask == '0 && (s.learned || !$past(s.free_hit));
   endproperty
   a_self_addr: assert property (p_self_addr) else $error("self addr"); // [RQ22]

   property p_group_clear;
      @(posedge ref_clk) disable iff (!reset_n)
      s.rdy && pkt_valid && !pkt_i.directed |=> ##17 s.lrn_new |-> !s.pkt.src[40];
   endproperty
   a_group_clear: assert property (p_group_clear) else $error("group bit"); // [RQ19]

   property p_learn_fields;
      @(posedge ref_clk) disable iff (!reset_n)
      s.lrn_new |-> s.tbl[s.lrn_idx][`SAL_F_UTYPE] == `SAL_UTYPE_LRN &&
      !s.tbl[s.lrn_idx][`SAL_F_BLOCK] && !s.tbl[s.lrn_idx][`SAL_F_SECURE];
   endproperty
   a_learn_fields: assert property (p_learn_fields) else $error("learn fields"); // [RQ21]

endmodule

// ==== sal_mac_model.sv ====
/*
 * Port MAC and switch fabric stand-in for the address lookup engine.
 * Assumes the bench calls send() and watches rx_count and last_fwd.
 */
`timescale 1ns/1ps
module sal_mac_model (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          reset_n,
   // Packets toward the engine
   output logic               pkt_valid,
   output sal_pkg::sal_pkt_t  pkt_i,
   input  wire logic          pkt_ready,
   // Results from the engine
   input  sal_pkg::sal_fwd_t  fwd_o
);
   logic              pass_error_frames;
   logic              pass_short_frames;
   logic              pass_control_frames;
   int                rx_count;
   sal_pkg::sal_fwd_t last_fwd;

   initial begin
      pkt_valid = 1'b0;
      pkt_i = '0;
      pass_error_frames = 1'b0;
      pass_short_frames = 1'b0;
      pass_control_frames = 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // Fabric takes every result pulse
   always @(posedge ref_clk) begin
      if (!reset_n)
         rx_count <= 0;
      else if (fwd_o.valid) begin
         rx_count <= rx_count + 1;
         last_fwd <= fwd_o;
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic send(input sal_pkg::sal_pkt_t p, output bit ok);
      int i;
      ok = 1'b0;
      if ((p.err && !(pass_error_frames || pass_short_frames)) || (p.ctrl && !pass_control_frames))
         p.aborted = 1'b1;
      @(posedge ref_clk);
      pkt_valid <= 1'b1;
      pkt_i <= p;
      for (i = 0; i < 64 && !ok; i++) begin
         @(posedge ref_clk);
         ok = pkt_ready;
      end
      pkt_valid <= 1'b0;
      // Released bus shows junk so a stale packet cannot pass
      pkt_i <= ~p;
   endtask
endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for the address lookup engine: APB master, table
 * setup, a row table of packets and table readback of learned entries.
 * Assumes sal_pkg, sal_engine and sal_mac_model are compiled first.
 */
`timescale 1ns/1ps
`include "sal_regs.svh"
module testbench;
   typedef struct packed {
      logic [3:0]  c;
      logic [1:0]  pt;
      logic [47:0] d;
      logic [47:0] s;
      logic [3:0]  f;
      logic [3:0]  e;
   } sal_row_t;
   localparam logic [47:0] a_uc = 48'h0000_0a00_0002, s_sup = 48'h0000_0a00_0003;
   localparam logic [47:0] x_src = 48'h0200_0000_0001, sp_src = 48'h00aa_bb00_0001;
   localparam logic [47:0] b_bc = 48'hffff_ffff_ffff, m_mc = 48'h0100_5e00_0001;
   localparam logic [47:0] y_dir = 48'h0000_0b00_0001, l_src = 48'h0000_0c00_0001;
   localparam logic [47:0] l2_src = 48'h0100_0d00_0001, l2_clr = 48'h0000_0d00_0001;
   localparam logic [47:0] e_src = 48'h0000_0e00_0001, q_src = 48'h0000_0f00_0001;

   logic              ref_clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [11:0]       paddr = 12'h000;
   logic [31:0]       pwdata = 32'h0;
   logic              pready, pslverr, er, pkt_valid, pkt_ready;
   logic [31:0]       prdata, rd;
   logic [69:0]       e;
   sal_pkg::sal_pkt_t pkt_i, p;
   sal_pkg::sal_fwd_t fwd_o;
   sal_row_t          rows[$];
   int                num_errors = 0;
   int                n_compared = 0;
   int                k, cnt;
   bit                ok;

   always #5 ref_clk = ~ref_clk;

   sal_engine u_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_i(pkt_i),
      .pkt_ready(pkt_ready), .fwd_o(fwd_o));
   sal_mac_model u_mac (
      .ref_clk(ref_clk), .reset_n(reset_n), .pkt_valid(pkt_valid), .pkt_i(pkt_i),
      .pkt_ready(pkt_ready), .fwd_o(fwd_o));

   ////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [69:0] g, input logic [69:0] x);
      n_compared++;
      if (g !== x) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         num_errors++;
         test_done();
      end
   endtask

   task automatic wr_ent(input logic [3:0] ix, input logic [9:0] c, input logic [47:0] a);
      apb(1'b1, `SAL_OFF_TBLW0, a[31:0]);
      apb(1'b1, `SAL_OFF_TBLW1, {c[3:0], 12'h000, a[47:32]});
      apb(1'b1, `SAL_OFF_TBLW2, {26'h0, c[9:4]});
      apb(1'b1, `SAL_OFF_TBLCTL, {1'b1, 27'h0, ix});
   endtask

   task automatic rd_ent(input logic [3:0] ix);
      apb(1'b1, `SAL_OFF_TBLCTL, {28'h0, ix});
      apb(1'b0, `SAL_OFF_TBLW0, 32'h0);
      e[31:0] = rd;
      apb(1'b0, `SAL_OFF_TBLW1, 32'h0);
      e[63:32] = rd;
      apb(1'b0, `SAL_OFF_TBLW2, 32'h0);
      e[69:64] = rd[5:0];
   endtask

   task automatic add(input logic [3:0] c, input logic [1:0] pt, input logic [47:0] d,
                      input logic [47:0] s, input logic [3:0] f, input logic [3:0] x);
      rows.push_back('{c, pt, d, s, f, x});
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      // Config {pass, deny, bypass, enable}; flags {err, ctrl, abort, directed}
      add(4'h0, 1, a_uc, x_src, 4'h0, 4'h0);
      add(4'h1, 1, a_uc, x_src, 4'h0, 4'h4);
      add(4'h9, 1, a_uc, x_src, 4'h8, 4'h1);
      add(4'h9, 2, a_uc, x_src, 4'h4, 4'h1);
      add(4'h1, 1, a_uc, x_src, 4'h8, 4'h0);
      add(4'h1, 1, a_uc, x_src, 4'h4, 4'h0);
      add(4'h3, 1, a_uc, x_src, 4'h0, 4'h1);
      add(4'h3, 0, a_uc, x_src, 4'h0, 4'h4);
      add(4'h1, 1, a_uc, sp_src, 4'h0, 4'h1);
      add(4'h1, 1, s_sup, sp_src, 4'h0, 4'h8);
      add(4'h1, 1, b_bc, sp_src, 4'h0, 4'hc);
      add(4'h1, 0, a_uc, y_dir, 4'h1, 4'h6);
      add(4'h1, 2, y_dir, x_src, 4'h0, 4'hb);
      add(4'h1, 3, a_uc, l_src, 4'h0, 4'h4);
      add(4'h1, 1, l_src, x_src, 4'h0, 4'h8);
      add(4'h1, 2, l_src, l2_src, 4'h0, 4'h8);
      add(4'h1, 1, l2_clr, x_src, 4'h0, 4'h4);
      add(4'h9, 2, a_uc, e_src, 4'h8, 4'h1);
      add(4'h1, 1, e_src, x_src, 4'h0, 4'hd);
      add(4'h1, 2, q_src, q_src, 4'h0, 4'h0);
      add(4'h1, 1, q_src, x_src, 4'h0, 4'h4);
      add(4'h5, 1, a_uc, x_src, 4'h0, 4'h1);
      add(4'h5, 1, s_sup, x_src, 4'h0, 4'h8);
      add(4'h5, 1, b_bc, x_src, 4'h0, 4'hc);
      add(4'h5, 1, m_mc, x_src, 4'h0, 4'h1);
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      chk({pready, pslverr, pkt_ready, fwd_o}, {3'b001, 7'h00});
      apb(1'b0, `SAL_OFF_STATUS, 32'h0);
      chk(rd[15:0], 16'h0010);
      apb(1'b0, `SAL_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      apb(1'b0, 12'h0f0, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      rd_ent(4'h5);
      chk(e[61:60], 2'h0);
      // Distinct addresses only, so no lookup is ambiguous
      wr_ent(4'h0, 10'h081, a_uc);
      wr_ent(4'h1, 10'h0f1, s_sup);
      wr_ent(4'h2, 10'h009, {24'h00aabb, 24'h0});
      wr_ent(4'h3, 10'h3ad, b_bc);
      rd_ent(4'h3);
      chk(e, {10'h3ad, 12'h000, b_bc});
      foreach (rows[i]) begin
         apb(1'b1, `SAL_OFF_CTRL, {29'h0, rows[i].c[2:0]});
         u_mac.pass_error_frames = rows[i].c[3] && !rows[i].pt[1];
         u_mac.pass_short_frames = rows[i].c[3] && rows[i].pt[1];
         u_mac.pass_control_frames = rows[i].c[3];
         p = '0;
         p.src_port = rows[i].pt;
         p.dst = rows[i].d;
         p.src = rows[i].s;
         p.ltype = 16'h0800;
         {p.err, p.ctrl, p.aborted, p.directed} = rows[i].f;
         p.dir_mask = 4'h6;
         cnt = u_mac.rx_count;
         u_mac.send(p, ok);
         for (k = 0; k < 40 && u_mac.rx_count == cnt; k++)
            @(posedge ref_clk);
         if (!ok || u_mac.rx_count == cnt) begin
            num_errors++;
            test_done();
         end
         chk(u_mac.last_fwd.mask, rows[i].e);
         if (rows[i].f[3] && rows[i].c[3])
            chk({u_mac.last_fwd.no_untag, u_mac.last_fwd.no_rate_drop}, 2'b11);
      end
      cnt = 0;
      for (k = 0; k < 16; k++) begin
         rd_ent(k[3:0]);
         if (e[47:0] === l_src) begin
            cnt++;
            chk(e[68:60], 9'h0cd);
         end
      end
      chk(cnt, 1);
      test_done();
   end
endmodule
